// ### hdl/acr_device.sv
// Notes on behaviour
// - count bit 0: eight inputs offered
// - count bit 1: ten inputs offered
// - eight inputs: reference choice picks reference
// - ten inputs: only reference one used
// - route channel from converter control bits
// - no new word until settling done
// - buffer bit clear: common input unbuffered
// - swap disable bit resets to zero
// - swap on: rate is modulator clock over 24*SF, 8*SF with swap off
// - swap on: rates 5.35 to 105.03 Hz
// - sinc3 plus sinc filter notch plan
// - SF 69 gives 19.8 Hz, 101 ms
// - serial words travel MSB first
// - host keeps sclk at most 3 MHz
// - host idles sclk high
// - host polls ready flag or pin
// - ready clears after read, reread allowed
// - 32 ones reset interface and registers
// - write named access follows comm byte directly
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"
module acr_device #(
	parameter int unsigned MOD_DIV = `ACR_MOD_DIV_DEF
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// serial link to host
	acr_if.device            link,
	// converter side
	input  wire logic [15:0] conv_sample,
	output logic      [3:0]  route_channel,
	output logic             route_valid,
	output logic             channel_count_select,
	output logic             use_reference_two,
	output logic             common_input_buffer_on,
	output logic             swap_enable,
	output logic      [7:0]  decimation_word,
	output logic             result_update
);
	import acr_pkg::*;

	// register length in bits for an address
	function automatic logic [4:0] reg_len(input logic [3:0] a);
		if (a == `ACR_REG_DATA) begin
			return 5'h10;
		end
		return 5'h08;
	endfunction : reg_len

	// decimation word clamped to the legal floor of the mode
	function automatic logic [7:0] eff_sf(input logic [7:0] sf, input logic swp);
		logic [7:0] lo;
		lo = swp ? `ACR_SF_MIN_SWAP : `ACR_SF_MIN_NOSWAP;
		return (sf < lo) ? lo : sf;
	endfunction : eff_sf

	// conversion period in modulator ticks
	function automatic logic [12:0] conv_period(input logic [7:0] sf, input logic swp);
		logic [4:0] mult;
		mult = swp ? `ACR_SWAP_MULT : `ACR_NOSWAP_MULT;
		return 13'(mult) * 13'(eff_sf(sf, swp));
	endfunction : conv_period

	acr_ser_t    state;       // serial state
	logic        sclk_q;      // sclk one cycle ago
	logic        rise;        // sclk rising edge seen
	logic        fall;        // sclk falling edge seen
	logic [4:0]  bit_cnt;     // bits taken in this field
	logic [15:0] in_sh;       // incoming shift register
	logic [15:0] out_sh;      // outgoing shift register
	logic [7:0]  byte_in;     // byte completed by the current bit
	logic [3:0]  acc_addr;    // address named by the last comm byte
	logic [4:0]  ones_cnt;    // consecutive ones on din
	logic        soft_rst;    // pulse after the ones sequence
	logic [7:0]  mode_reg;    // mode register
	logic [7:0]  conv_reg;    // converter control register
	logic [7:0]  filt_reg;    // filter register
	logic [15:0] data_reg;    // latest result
	logic        rdy;         // result not yet read
	logic [15:0] rd_word;     // left aligned read value
	logic        comm_done;   // comm byte finishes this cycle
	logic        field_done;  // data field finishes this cycle
	logic        cfg_write;   // a writable register is updated
	logic        data_read;   // data register read completes
	logic [15:0] mod_cnt;     // modulator tick divider
	logic        mod_tick;    // one modulator clock
	logic [12:0] conv_cnt;    // ticks into the conversion
	logic [1:0]  discard;     // conversions still settling
	logic        conv_done;   // valid conversion ends

	// edge detect; inputs are synchronous to hclk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_q <= 1'b1;
		end else begin
			sclk_q <= link.sclk;
		end
	end
	assign rise = link.sclk & ~sclk_q;
	assign fall = ~link.sclk & sclk_q;

	// incoming byte, MSB first
	assign byte_in    = {in_sh[6:0], link.din};
	assign comm_done  = rise && !link.cs_n && (state == ACR_S_COMM) && (bit_cnt == 5'h07);
	assign field_done = rise && !link.cs_n && (state != ACR_S_COMM)
		&& (bit_cnt == reg_len(acc_addr) - 5'h01);
	assign cfg_write  = field_done && (state == ACR_S_WR) && !soft_rst;
	assign data_read  = field_done && (state == ACR_S_RD) && (acc_addr == `ACR_REG_DATA);

	// serial field sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state    <= ACR_S_COMM;
			bit_cnt  <= 5'h00;
			in_sh    <= 16'h0000;
			acc_addr <= 4'h0;
		end else if (soft_rst) begin
			// back to waiting for a comm write
			state   <= ACR_S_COMM;
			bit_cnt <= 5'h00;
		end else if (link.cs_n) begin
			// frame dropped: restart the field count
			bit_cnt <= 5'h00;
		end else if (rise) begin
			in_sh <= {in_sh[14:0], link.din};
			if (comm_done) begin
				// next access set up at once, no gap needed
				bit_cnt  <= 5'h00;
				acc_addr <= byte_in[3:0];
				if (byte_in[`ACR_COMM_RD_BIT]) begin
					state <= ACR_S_RD;
				end else if (byte_in[3:0] == `ACR_REG_MODE || byte_in[3:0] == `ACR_REG_CONV
					|| byte_in[3:0] == `ACR_REG_FILTER) begin
					state <= ACR_S_WR;
				end else begin
					// read-only target: write ignored
					state <= ACR_S_COMM;
				end
			end else if (field_done) begin
				state   <= ACR_S_COMM;
				bit_cnt <= 5'h00;
			end else begin
				bit_cnt <= bit_cnt + 5'h01;
			end
		end
	end

	// ones counter for the interface reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ones_cnt <= 5'h00;
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= 1'b0;
			if (soft_rst) begin
				ones_cnt <= 5'h00;
			end else if (rise && !link.cs_n) begin
				if (!link.din) begin
					ones_cnt <= 5'h00;
				end else if (ones_cnt == 5'(`ACR_ONES_RESET - 1)) begin
					soft_rst <= 1'b1;
				end else begin
					ones_cnt <= ones_cnt + 5'h01;
				end
			end
		end
	end

	// read value mux, left aligned so the MSB leaves first
	always_comb begin
		rd_word = 16'h0000;
		if (byte_in[3:0] == `ACR_REG_STATUS) begin
			rd_word[15 - 7 + `ACR_STAT_RDY] = rdy;
		end else if (byte_in[3:0] == `ACR_REG_MODE) begin
			rd_word = {mode_reg, 8'h00};
		end else if (byte_in[3:0] == `ACR_REG_CONV) begin
			rd_word = {conv_reg, 8'h00};
		end else if (byte_in[3:0] == `ACR_REG_FILTER) begin
			rd_word = {filt_reg, 8'h00};
		end else if (byte_in[3:0] == `ACR_REG_DATA) begin
			rd_word = data_reg;
		end
	end

	// output shifter: loaded as the comm byte ends, shifted on falling sclk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_sh    <= 16'h0000;
			link.dout <= 1'b1;
		end else if (comm_done) begin
			out_sh <= rd_word;
		end else if (fall && state == ACR_S_RD && !link.cs_n) begin
			link.dout <= out_sh[15];
			out_sh    <= {out_sh[14:0], 1'b0};
		end
	end
	// not full duplex: dout driven only in a read field
	assign link.dout_oe = (state == ACR_S_RD) && !link.cs_n;

	// configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_reg <= `ACR_MODE_RESET;
			conv_reg <= `ACR_CONV_RESET;
			filt_reg <= `ACR_FILTER_RESET;
		end else if (soft_rst) begin
			// every register back to its power-on value
			mode_reg <= `ACR_MODE_RESET;
			conv_reg <= `ACR_CONV_RESET;
			filt_reg <= `ACR_FILTER_RESET;
		end else if (cfg_write) begin
			if (acc_addr == `ACR_REG_MODE) begin
				mode_reg <= byte_in;
			end else if (acc_addr == `ACR_REG_CONV) begin
				conv_reg <= byte_in;
			end else if (acc_addr == `ACR_REG_FILTER) begin
				filt_reg <= byte_in;
			end
		end
	end

	// modulator clock from a divider on hclk
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mod_cnt <= 16'h0000;
		end else if (mod_cnt == 16'(MOD_DIV - 1)) begin
			mod_cnt <= 16'h0000;
		end else begin
			mod_cnt <= mod_cnt + 16'h0001;
		end
	end
	assign mod_tick = (mod_cnt == 16'(MOD_DIV - 1));

	// conversion timing; any config write restarts and re-settles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conv_cnt <= 13'h0000;
			discard  <= `ACR_SETTLE_DISCARD;
		end else if (soft_rst || cfg_write) begin
			conv_cnt <= 13'h0000;
			discard  <= `ACR_SETTLE_DISCARD;
		end else if (mod_tick) begin
			if (conv_cnt == conv_period(filt_reg, swap_enable) - 13'h0001) begin
				// period is 24*SF ticks with swapping, 8*SF without
				conv_cnt <= 13'h0000;
				if (discard != 2'h0) begin
					discard <= discard - 2'h1;
				end
			end else begin
				conv_cnt <= conv_cnt + 13'h0001;
			end
		end
	end
	// SF clamp keeps the swap rate within 5.35..105.03 Hz at 32.768 kHz
	assign conv_done = mod_tick && !soft_rst && !cfg_write && (discard == 2'h0)
		&& (conv_cnt == conv_period(filt_reg, swap_enable) - 13'h0001);

	// result register and its update strobe
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_reg      <= 16'h0000;
			result_update <= 1'b0;
		end else begin
			result_update <= conv_done;
			if (soft_rst) begin
				data_reg <= 16'h0000;
			end else if (conv_done) begin
				data_reg <= conv_sample;
			end
		end
	end

	// ready flag: a new result wins over the read that clears it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdy <= 1'b0;
		end else if (conv_done) begin
			rdy <= 1'b1;
		end else if (soft_rst || data_read) begin
			// a read leaves the data in place, so a second read still sees it
			rdy <= 1'b0;
		end
	end
	assign link.rdy_n = ~rdy;

	// analog routing controls
	assign channel_count_select = mode_reg[`ACR_MODE_CHCOUNT];
	assign route_channel        = conv_reg[`ACR_CONV_CH_HI:`ACR_CONV_CH_LO];
	// eight or ten inputs offered depending on the count bit
	assign route_valid = route_channel < (channel_count_select ? `ACR_CH_LIMIT_TEN
		: `ACR_CH_LIMIT_EIGHT);
	// ten-input mode forces reference one whatever the choice bit says
	assign use_reference_two = ~channel_count_select
		& mode_reg[`ACR_MODE_REFCHOICE];
	assign common_input_buffer_on = mode_reg[`ACR_MODE_COMBUF];
	// swap bit is active-high disable; the notch plan follows this mode
	assign swap_enable     = ~mode_reg[`ACR_MODE_SWAP_DIS];
	assign decimation_word = filt_reg;
endmodule : acr_device
`default_nettype wire

// ### hdl/acr_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"
module acr_host (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	// serial link to device
	acr_if.host              link
);
	import acr_pkg::*;

	acr_hst_t    state;     // serial master state
	logic        ph_valid;  // data phase pending
	logic        ph_write;  // data phase is a write
	logic [31:0] ph_addr;   // latched address
	logic [2:0]  div;       // half period counter
	logic [31:0] tx_sh;     // outgoing bits, MSB first
	logic [5:0]  nbits;     // bits in this frame
	logic [5:0]  sent;      // bits clocked so far
	logic [15:0] rx_sh;     // incoming bits
	logic [15:0] rdata;     // last received word
	logic        busy;      // frame in progress
	logic        start;     // control write accepted

	// address phase capture; hsize is always a word here
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr  <= 32'h0000_0000;
		end else if (hready) begin
			ph_valid <= hsel && htrans[1];
			ph_write <= hwrite;
			ph_addr  <= haddr;
		end
	end
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign busy      = (state != ACR_H_IDLE);
	// writes while a frame runs are dropped
	assign start     = ph_valid && ph_write && (ph_addr == `ACR_H_CTRL) && !busy;

	// read data mux
	always_comb begin
		hrdata = 32'h0000_0000;
		if (ph_addr == `ACR_H_STATUS) begin
			hrdata[`ACR_H_ST_BUSY]  = busy;
			hrdata[`ACR_H_ST_READY] = ~link.rdy_n;
		end else if (ph_addr == `ACR_H_RDATA) begin
			hrdata[15:0] = rdata;
		end
	end

	// serial master; sclk from a divider, never faster than the limit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state     <= ACR_H_IDLE;
			link.sclk <= 1'b1;
			link.din  <= 1'b1;
			link.cs_n <= 1'b1;
			div       <= 3'h0;
			tx_sh     <= 32'h0000_0000;
			nbits     <= 6'h00;
			sent      <= 6'h00;
			rx_sh     <= 16'h0000;
			rdata     <= 16'h0000;
		end else begin
			case (state)
				ACR_H_IDLE: begin
					// clock parked high between frames
					link.sclk <= 1'b1;
					if (start) begin
						link.cs_n <= 1'b0;
						div       <= 3'h0;
						sent      <= 6'h00;
						state     <= ACR_H_LOW;
						if (hwdata[`ACR_H_RESYNC]) begin
							tx_sh <= 32'hFFFF_FFFF;
							nbits <= 6'h20;
						end else if (hwdata[`ACR_H_LEN_HI:`ACR_H_LEN_LO] == 2'h0) begin
							tx_sh <= {hwdata[7:0], 24'h00_0000};
							nbits <= 6'h08;
						end else if (hwdata[`ACR_H_LEN_HI:`ACR_H_LEN_LO] == 2'h1) begin
							tx_sh <= {hwdata[7:0], hwdata[15:8], 16'h0000};
							nbits <= 6'h10;
						end else begin
							tx_sh <= {hwdata[7:0], hwdata[23:8], 8'h00};
							nbits <= 6'h18;
						end
					end
				end
				ACR_H_LOW: begin
					if (div == 3'(`ACR_SCLK_HALF - 1)) begin
						div <= 3'h0;
						if (sent == nbits) begin
							// frame over half a period after the last rise
							link.cs_n <= 1'b1;
							link.din  <= 1'b1;
							rdata     <= rx_sh;
							state     <= ACR_H_IDLE;
						end else begin
							link.sclk <= 1'b0;
							link.din  <= tx_sh[31];
							tx_sh     <= {tx_sh[30:0], 1'b1};
							state     <= ACR_H_HIGH;
						end
					end else begin
						div <= div + 3'h1;
					end
				end
				ACR_H_HIGH: begin
					if (div == 3'(`ACR_SCLK_HALF - 1)) begin
						div       <= 3'h0;
						link.sclk <= 1'b1;
						rx_sh     <= {rx_sh[14:0], link.dout};
						sent      <= sent + 6'h01;
						state     <= ACR_H_LOW;
					end else begin
						div <= div + 3'h1;
					end
				end
				default: begin
					state <= ACR_H_IDLE;
				end
			endcase
		end
	end
endmodule : acr_host
`default_nettype wire

// ### shared/acr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acr_if;
	logic sclk;     // serial clock, idles high
	logic din;      // host to device data
	logic dout;     // device to host data
	logic dout_oe;  // device drives dout
	logic cs_n;     // frame select, active low
	logic rdy_n;    // result ready, active low
	modport device (input sclk, input din, input cs_n, output dout, output dout_oe, output rdy_n);
	modport host (output sclk, output din, output cs_n, input dout, input dout_oe, input rdy_n);
endinterface : acr_if
`default_nettype wire

// ### shared/acr_params.svh
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// system clock and serial clock limit, in kHz
`define ACR_CLK_KHZ          10000
`define ACR_SCLK_MAX_KHZ     3000
// host half period of sclk in hclk cycles, rounded up so sclk stays at or below the limit
`define ACR_SCLK_HALF        ((`ACR_CLK_KHZ + 2 * `ACR_SCLK_MAX_KHZ - 1) / (2 * `ACR_SCLK_MAX_KHZ))

// modulator tick divider default (hclk cycles per modulator clock)
`define ACR_MOD_DIV_DEF      305

// device register addresses, low four bits of the communications byte
`define ACR_REG_STATUS       4'h0
`define ACR_REG_MODE         4'h1
`define ACR_REG_CONV         4'h2
`define ACR_REG_FILTER       4'h3
`define ACR_REG_DATA         4'h4
// communications byte: read request bit
`define ACR_COMM_RD_BIT      6

// mode register fields and reset value
`define ACR_MODE_SWAP_DIS    7
`define ACR_MODE_CHCOUNT     4
`define ACR_MODE_COMBUF      2
`define ACR_MODE_REFCHOICE   1
`define ACR_MODE_RESET       8'h00
// converter control register: channel select field, reset value
`define ACR_CONV_CH_HI       7
`define ACR_CONV_CH_LO       4
`define ACR_CONV_RESET       8'h00
// filter register reset value (decimation word 69)
`define ACR_FILTER_RESET     8'h45
// status register: ready flag position
`define ACR_STAT_RDY         7

// rate arithmetic
`define ACR_SWAP_MULT        5'h18
`define ACR_NOSWAP_MULT      5'h08
`define ACR_SF_MIN_SWAP      8'h0D
`define ACR_SF_MIN_NOSWAP    8'h03
`define ACR_CH_LIMIT_EIGHT   4'h8
`define ACR_CH_LIMIT_TEN     4'hA
// serial reset by ones, and conversions thrown away after a change
`define ACR_ONES_RESET       32
`define ACR_SETTLE_DISCARD   2'h1

// host register map on the AHB-Lite side
`define ACR_H_CTRL           32'h0000_0000
`define ACR_H_STATUS         32'h0000_0004
`define ACR_H_RDATA          32'h0000_0008
`define ACR_H_LEN_HI         25
`define ACR_H_LEN_LO         24
`define ACR_H_RESYNC         26
`define ACR_H_ST_BUSY        0
`define ACR_H_ST_READY       1

`endif

// ### shared/acr_pkg.sv
`default_nettype none
package acr_pkg;
	// device serial states
	typedef enum logic [2:0] {
		ACR_S_COMM = 3'b001,
		ACR_S_WR   = 3'b010,
		ACR_S_RD   = 3'b100
	} acr_ser_t;
	// host serial master states
	typedef enum logic [2:0] {
		ACR_H_IDLE = 3'b001,
		ACR_H_LOW  = 3'b010,
		ACR_H_HIGH = 3'b100
	} acr_hst_t;
endpackage : acr_pkg
`default_nettype wire

// ### test/acr_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module acr_assertions (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// serial link
	input wire logic sclk,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic cs_n,
	input wire logic rdy_n
);
	logic       sclk_q; // sclk one cycle ago
	logic       rise;   // sclk rise this cycle
	logic [5:0] nbits;  // rises in the open frame
	logic [5:0] nones;  // run of ones on din
	assign rise = sclk & ~sclk_q;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// sclk history, idles high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) sclk_q <= 1'b1;
		else sclk_q <= sclk;
	end
	// counts restart with each frame; ones run saturates so it never wraps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nbits <= 6'h00;
			nones <= 6'h00;
		end else if (cs_n) begin
			nbits <= 6'h00;
			nones <= 6'h00;
		end else if (rise) begin
			nbits <= nbits + 6'h01;
			nones <= din ? nones + {5'h00, nones != 6'h3F} : 6'h00;
		end
	end
	link_idle_a: assert property (cs_n && $past(cs_n) |-> sclk && din)
		else $error("link not idle high between frames");
	sclk_frame_a: assert property ($changed(sclk) |-> !cs_n)
		else $error("sclk moved outside a frame");
	sclk_low_a: assert property ($fell(sclk) |=> !sclk)
		else $error("sclk low phase too short");
	sclk_high_a: assert property ($rose(sclk) |=> sclk)
		else $error("sclk high phase too short");
	frame_lead_a: assert property ($fell(cs_n) |-> sclk [*2])
		else $error("sclk not high at frame start");
	frame_tail_a: assert property ($rose(cs_n) |-> $past(sclk) && $past(sclk, 2))
		else $error("sclk not high at frame end");
	frame_len_a: assert property ($rose(cs_n) |-> nbits[2:0] == 3'h0 && nbits != 6'h00)
		else $error("frame not whole bytes");
	din_hold_a: assert property (sclk && $past(sclk) && !cs_n |-> $stable(din))
		else $error("din moved while sclk high");
	half_duplex_a: assert property (dout_oe |-> !cs_n)
		else $error("dout driven outside a frame");
	soft_reset_a: assert property (rise && din && nones == 6'h1F |-> ##[1:4] rdy_n && !dout_oe)
		else $error("ones run did not reset the link");
	rdy_clear_a: assert property ($rose(rdy_n) |-> !$past(cs_n) || !$past(cs_n, 2) || !$past(cs_n, 3))
		else $error("ready released with no read");
	// main scenarios reached
	cover property ($rose(cs_n) && nbits == 6'h18);
	cover property ($fell(rdy_n));
	cover property (rise && din && nones == 6'h1F);
	cover property (dout_oe && !dout);
endmodule : acr_assertions
`default_nettype wire

// ### test/adc_channel_rate_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"
module adc_channel_rate_control_test;
	// clock, reset, tallies
	logic        hclk;
	logic        hresetn;
	int          num_errors;
	int          n_tests;
	// ahb master
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	// converter side
	logic [15:0] conv_sample;
	logic [3:0]  route_channel;
	logic        route_valid, channel_count_select, use_reference_two;
	logic        common_input_buffer_on, swap_enable, result_update;
	logic [7:0]  decimation_word;
	logic [8:0]  outs;
	// wire monitor, msb first shift
	logic        sclk_d;
	logic [31:0] mon_din;
	logic [31:0] mon_dout;
	// scratch
	logic [31:0] got;
	logic [7:0]  md, sf;
	logic [3:0]  ch;
	logic [31:0] p;
	int          gap;
	logic [11:0] corner [6] = '{12'h027, 12'h028, 12'h129, 12'h12A, 12'h84F, 12'h160};
	logic [8:0]  rates [5] = '{9'h10D, 9'h105, 9'h145, 9'h003, 9'h011};

	acr_if link_if();
	acr_device #(.MOD_DIV(1)) acr_device_i (.hclk(hclk), .hresetn(hresetn),
		.link(link_if.device), .conv_sample(conv_sample), .route_channel(route_channel),
		.route_valid(route_valid), .channel_count_select(channel_count_select),
		.use_reference_two(use_reference_two), .common_input_buffer_on(common_input_buffer_on),
		.swap_enable(swap_enable), .decimation_word(decimation_word),
		.result_update(result_update));
	acr_host acr_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link_if.host));
	acr_assertions acr_assertions_i (.hclk(hclk), .hresetn(hresetn), .sclk(link_if.sclk),
		.din(link_if.din), .dout(link_if.dout), .dout_oe(link_if.dout_oe),
		.cs_n(link_if.cs_n), .rdy_n(link_if.rdy_n));
	assign outs = {route_channel, route_valid, channel_count_select, use_reference_two,
		common_input_buffer_on, swap_enable};

	// 10 MHz clock
	initial hclk = 1'b0;
	always #50 hclk = ~hclk;

	// one cycle after a rise both lines are settled
	always @(posedge hclk) begin
		sclk_d <= link_if.sclk;
		if (link_if.sclk && !sclk_d && !link_if.cs_n) begin
			mon_din  <= {mon_din[30:0], link_if.din};
			mon_dout <= {mon_dout[30:0], link_if.dout};
		end
	end

	// expected converter-side levels for a mode byte and channel
	function automatic logic [8:0] exp_outs(input logic [7:0] m, input logic [3:0] c);
		return {c, c < (m[4] ? 4'hA : 4'h8), m[4], ~m[4] & m[1], m[2], ~m[7]};
	endfunction : exp_outs

	// result spacing in hclk cycles, decimation word clamped to its floor
	function automatic logic [31:0] exp_period(input logic [7:0] s, input logic swap);
		logic [7:0] c;
		c = swap ? ((s < 8'h0D) ? 8'h0D : s) : ((s < 8'h03) ? 8'h03 : s);
		return swap ? {24'h0, c} * 24 : {24'h0, c} * 8;
	endfunction : exp_period

	// compare and tally
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("BAD at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// single ahb transfer, each phase held until hready
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rv);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rv = hrdata;
	endtask : ahb

	// serial frame through the host; busy polled so no order is dropped
	task automatic frame(input logic [7:0] c, input logic [15:0] d, input logic [1:0] n,
		input logic rs, output logic [31:0] r);
		logic [31:0] st;
		ahb(1'b1, `ACR_H_CTRL, {5'h00, rs, n, d, c}, st);
		st = 32'h0000_0001;
		while (st[`ACR_H_ST_BUSY] !== 1'b0) ahb(1'b0, `ACR_H_STATUS, 32'h0000_0000, st);
		ahb(1'b0, `ACR_H_RDATA, 32'h0000_0000, r);
	endtask : frame

	// register write, wire order checked
	task automatic wreg(input logic [3:0] a, input logic [7:0] v);
		frame({4'h0, a}, {8'h00, v}, 2'h1, 1'b0, got);
		chk(mon_din[15:0], {4'h0, a, v});
	endtask : wreg

	// register read, wire order checked, value compared
	task automatic rreg(input logic [3:0] a, input logic [7:0] e);
		frame({4'h4, a}, 16'h0000, 2'h1, 1'b0, got);
		chk(mon_dout[7:0], got[7:0]);
		chk(got[7:0], e);
	endtask : rreg

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// hang guard, well beyond the expected run
	initial begin
		#4000000;
		num_errors++;
		give_verdict();
	end

	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		conv_sample = 16'h0000;
		num_errors = 0;
		n_tests = 0;
		void'($urandom(50));
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		// reset state, and an unmapped read gives zero
		rreg(`ACR_REG_MODE, `ACR_MODE_RESET);
		rreg(`ACR_REG_FILTER, 8'h45);
		chk(outs, exp_outs(8'h00, 4'h0));
		ahb(1'b0, 32'h0000_0010, 32'h0000_0000, got);
		chk(got, 32'h0000_0000);
		chk(hresp, 1'b0);
		$display("reset test done");
		// arrangement, reference, buffer, swap and channel routing
		for (int i = 0; i < 20; i++) begin
			md = (i < 6) ? corner[i][11:4] : 8'($urandom) & 8'h96;
			ch = (i < 6) ? corner[i][3:0] : 4'($urandom);
			wreg(`ACR_REG_MODE, md);
			wreg(`ACR_REG_CONV, {ch, 4'h0});
			chk(outs, exp_outs(md, ch));
			rreg(`ACR_REG_CONV, {ch, 4'h0});
		end
		$display("channel test done");
		// output rate, settling, ready and reread
		for (int i = 0; i < 5; i++) begin
			// random word keeps the period long enough that a read ends before the next update
			sf = (i == 4) ? 8'h0E + 8'($urandom % 30) : rates[i][7:0];
			conv_sample <= 16'($urandom);
			wreg(`ACR_REG_MODE, {~rates[i][8], 7'h00});
			wreg(`ACR_REG_FILTER, sf);
			chk(decimation_word, sf);
			wreg(`ACR_REG_CONV, 8'h30);
			p = exp_period(sf, rates[i][8]);
			gap = 0;
			while (result_update !== 1'b1) begin
				@(posedge hclk);
				gap++;
			end
			chk(32'(gap <= 2 * p && gap + 24 >= 2 * p), 32'h0000_0001);
			gap = 0;
			do begin
				@(posedge hclk);
				gap++;
			end while (result_update !== 1'b1);
			chk(gap, p);
			chk(link_if.rdy_n, 1'b0);
			ahb(1'b0, `ACR_H_STATUS, 32'h0000_0000, got);
			chk(got[`ACR_H_ST_READY], 1'b1);
			frame(8'h44, 16'h0000, 2'h2, 1'b0, got);
			chk(got[15:0], conv_sample);
			chk(mon_dout[15:0], conv_sample);
			chk(link_if.rdy_n, 1'b1);
			frame(8'h44, 16'h0000, 2'h2, 1'b0, got);
			chk(got[15:0], conv_sample);
		end
		$display("rate test done");
		// run of ones restores every register
		wreg(`ACR_REG_MODE, 8'h96);
		wreg(`ACR_REG_CONV, 8'h90);
		frame(8'hFF, 16'hFFFF, 2'h0, 1'b1, got);
		chk(mon_din, 32'hFFFF_FFFF);
		chk(outs, exp_outs(8'h00, 4'h0));
		chk(decimation_word, 8'h45);
		chk(link_if.rdy_n, 1'b1);
		// write to a read-only target is dropped; the trailing byte is a harmless comm byte
		wreg(`ACR_REG_DATA, 8'h80);
		chk(decimation_word, 8'h45);
		rreg(`ACR_REG_MODE, `ACR_MODE_RESET);
		$display("soft reset test done");
		give_verdict();
	end
endmodule : adc_channel_rate_control_test
`default_nettype wire
